/* spg_defs.vh */
// constants and timing counts for the socket glue block
`ifndef SPG_DEFS_VH
`define SPG_DEFS_VH
// ***************************************************************
// register map (byte addresses)
// ***************************************************************
`define SPG_CTRL_OFF 12'h000
`define SPG_STAT_OFF 12'h004
`define SPG_ID0_LO_OFF 12'h008
`define SPG_ID0_HI_OFF 12'h00C
`define SPG_ID1_LO_OFF 12'h010
`define SPG_ID1_HI_OFF 12'h014
`define SPG_RUN_OFF 12'h018
// ***************************************************************
// control fields, per port p at bit base 8*p
// ***************************************************************
`define SPG_C_TXDIS 0
`define SPG_C_RS0 1
`define SPG_C_RS1 2
`define SPG_C_PWR 3
`define SPG_C_SCL 4
`define SPG_C_SDA 5
`define SPG_PORT_STRIDE 8
`define SPG_CTRL_RST 32'h0000_0101
// ***************************************************************
// status fields, per port p at bit base 8*p
// ***************************************************************
`define SPG_S_FAULT 0
`define SPG_S_LOS 1
`define SPG_S_PRES 2
`define SPG_S_VALID 3
`define SPG_S_PGOOD 4
`define SPG_S_SCL 5
`define SPG_S_SDA 6
`define SPG_S_PFAIL 7
// ***************************************************************
// run register field and socket clock divider
// ***************************************************************
`define SPG_RUN_BIT 0
`define SPG_CLK_HZ 200000000
`define SPG_SOCK_HZ 40000000
// pclk cycles in one socket clock period, and how many of them high
`define SPG_SOCK_DIV (`SPG_CLK_HZ / `SPG_SOCK_HZ)
`define SPG_SOCK_HIGH (`SPG_SOCK_DIV / 2)
`endif

/* spg_sync3.v */
// three-flop synchroniser with agreement filter for one async input
`include "spg_defs.vh"
module spg_sync3 (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // async level in, filtered level out
  input wire async_in,
  output reg level_out
);
  reg s1_reg; // first stage, read only by s2
  reg s2_reg; // second stage
  reg s3_reg; // third stage
  // ***************************************************************
  // shift chain and agreement
  // ***************************************************************
  // a change counts only once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule // spg_sync3

/* spg_glue.v */
// socket glue top: apb registers, status sync, port controls
`include "spg_defs.vh"
module spg_glue (
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // socket clock and reset toward user logic
  output reg socket_clock_forty,
  output reg async_reset_in,
  // per-port async status from cages
  input wire [1:0] tx_fault_in,
  input wire [1:0] rx_signal_lost,
  input wire [1:0] module_present_flag,
  input wire [1:0] station_id_valid,
  input wire [95:0] port_station_id,
  // power handshake per port
  output reg [1:0] port_power_on,
  input wire [1:0] port_power_ok,
  // per-port controls to cages
  output reg [1:0] tx_disable_out,
  output reg [3:0] rate_select_out,
  // open-drain management lines
  input wire [1:0] module_mgmt_clock_i,
  output reg [1:0] module_mgmt_clock_o,
  output reg [1:0] module_mgmt_clock_oe,
  input wire [1:0] module_mgmt_data_i,
  output reg [1:0] module_mgmt_data_o,
  output reg [1:0] module_mgmt_data_oe
);
  // ***************************************************************
  // declarations
  // ***************************************************************
  reg [31:0] ctrl_reg; // per-port controls
  reg run_reg; // host run state, low holds reset
  reg [7:0] div_reg; // socket clock divider
  reg [1:0] pfail_reg; // sticky power loss while enabled
  reg [95:0] id_reg; // captured station addresses
  wire [1:0] fault_s; // synchronised fault
  wire [1:0] los_s; // synchronised loss of signal
  wire [1:0] pres_s; // synchronised presence
  wire [1:0] valid_s; // synchronised address valid
  wire [1:0] pgood_s; // synchronised power good
  wire [1:0] scl_s; // synchronised mgmt clock level
  wire [1:0] sda_s; // synchronised mgmt data level
  wire acc; // apb access phase
  wire wr_go; // apb write completes at the pready edge
  reg [31:0] stat_w; // assembled status word
  integer k; // loop index, status assembly only
  integer j; // loop index, register process only
  integer m; // loop index, output process only
  // address decode used for read and write
  // an unmapped offset decodes to zero, which raises pslverr
  function [2:0] dec;
    input [11:0] a;
    begin
      case (a)
        `SPG_CTRL_OFF: dec = 3'h1;
        `SPG_STAT_OFF: dec = 3'h2;
        `SPG_ID0_LO_OFF: dec = 3'h3;
        `SPG_ID0_HI_OFF: dec = 3'h4;
        `SPG_ID1_LO_OFF: dec = 3'h5;
        `SPG_ID1_HI_OFF: dec = 3'h6;
        `SPG_RUN_OFF: dec = 3'h7;
        default: dec = 3'h0;
      endcase
    end
  endfunction
  assign acc = psel & penable & ~pready;
  // a write takes effect only at the edge where the master sees pready high
  assign wr_go = psel & penable & pready & pwrite;
  // ***************************************************************
  // synchronisers for every async status line except the station id bus
  // ***************************************************************
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      spg_sync3 u_flt (.pclk(pclk), .presetn(presetn), .async_in(tx_fault_in[p]), .level_out(fault_s[p]));
      spg_sync3 u_los (.pclk(pclk), .presetn(presetn), .async_in(rx_signal_lost[p]), .level_out(los_s[p]));
      // presence polarity is passed raw; software confirms its meaning
      spg_sync3 u_prs (.pclk(pclk), .presetn(presetn), .async_in(module_present_flag[p]),
        .level_out(pres_s[p]));
      spg_sync3 u_val (.pclk(pclk), .presetn(presetn), .async_in(station_id_valid[p]),
        .level_out(valid_s[p]));
      spg_sync3 u_pg (.pclk(pclk), .presetn(presetn), .async_in(port_power_ok[p]), .level_out(pgood_s[p]));
      // line levels read back so software can run the two-wire bus by hand
      spg_sync3 u_scl (.pclk(pclk), .presetn(presetn), .async_in(module_mgmt_clock_i[p]),
        .level_out(scl_s[p]));
      spg_sync3 u_sda (.pclk(pclk), .presetn(presetn), .async_in(module_mgmt_data_i[p]),
        .level_out(sda_s[p]));
    end
  endgenerate
  // ***************************************************************
  // status word assembly
  // ***************************************************************
  always @* begin
    stat_w = 32'h0000_0000;
    for (k = 0; k < 2; k = k + 1) begin
      stat_w[k*`SPG_PORT_STRIDE+`SPG_S_FAULT] = fault_s[k];
      stat_w[k*`SPG_PORT_STRIDE+`SPG_S_LOS] = los_s[k];
      stat_w[k*`SPG_PORT_STRIDE+`SPG_S_PRES] = pres_s[k];
      stat_w[k*`SPG_PORT_STRIDE+`SPG_S_VALID] = valid_s[k];
      stat_w[k*`SPG_PORT_STRIDE+`SPG_S_PGOOD] = pgood_s[k];
      stat_w[k*`SPG_PORT_STRIDE+`SPG_S_SCL] = scl_s[k];
      stat_w[k*`SPG_PORT_STRIDE+`SPG_S_SDA] = sda_s[k];
      stat_w[k*`SPG_PORT_STRIDE+`SPG_S_PFAIL] = pfail_reg[k];
    end
  end
  // ***************************************************************
  // socket clock: free-running divider, never gated
  // ***************************************************************
  // runs from reset release on, independent of any cage state
  // an odd divide cannot give a square wave: high for two cycles, low
  // for three, which keeps the rate exact at the cost of the duty
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 8'h00;
      socket_clock_forty <= 1'b0;
    end else if (div_reg == (`SPG_SOCK_DIV - 1)) begin
      // wrap: start of the high phase
      div_reg <= 8'h00;
      socket_clock_forty <= 1'b1;
    end else begin
      div_reg <= div_reg + 8'h01;
      if (div_reg == (`SPG_SOCK_HIGH - 1)) begin
        // end of the high phase
        socket_clock_forty <= 1'b0;
      end
    end
  end
  // ***************************************************************
  // apb slave and registers
  // ***************************************************************
  // one wait state: access taken at the edge where pready is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SPG_CTRL_RST;
      run_reg <= 1'b0;
      pfail_reg <= 2'b00;
      id_reg <= 96'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      pslverr <= acc & (dec(paddr) == 3'h0);
      // capture each address only while its valid flag holds
      for (j = 0; j < 2; j = j + 1) begin
        if (valid_s[j]) begin
          id_reg[j*48 +: 48] <= port_station_id[j*48 +: 48];
        end
        // power loss while enabled: set wins over clear
        // limitation: a fresh power-up also sets it until power good has
        // crossed the synchroniser, so software clears it once the port is up
        if (ctrl_reg[j*`SPG_PORT_STRIDE+`SPG_C_PWR] & ~pgood_s[j]) begin
          pfail_reg[j] <= 1'b1;
        end else if (wr_go & (dec(paddr) == 3'h2) & pwdata[j*`SPG_PORT_STRIDE+`SPG_S_PFAIL]) begin
          pfail_reg[j] <= 1'b0;
        end
      end
      // writes land at the edge where the master sees pready high
      if (wr_go) begin
        case (dec(paddr))
          3'h1: ctrl_reg <= pwdata;
          3'h7: run_reg <= pwdata[`SPG_RUN_BIT];
          default: ;
        endcase
      end
      // read data loads one edge early so it stands while pready is high
      if (acc & ~pwrite) begin
        case (dec(paddr))
          3'h1: prdata <= ctrl_reg;
          3'h2: prdata <= stat_w;
          // address reads as zero unless currently valid
          3'h3: prdata <= valid_s[0] ? id_reg[31:0] : 32'h0000_0000;
          3'h4: prdata <= valid_s[0] ? {16'h0000, id_reg[47:32]} : 32'h0000_0000;
          3'h5: prdata <= valid_s[1] ? id_reg[79:48] : 32'h0000_0000;
          3'h6: prdata <= valid_s[1] ? {16'h0000, id_reg[95:80]} : 32'h0000_0000;
          3'h7: prdata <= {31'h0, run_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ***************************************************************
  // registered outputs to user logic and cages
  // ***************************************************************
  // reset out high from power-up until software writes run
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_reset_in <= 1'b1;
      port_power_on <= 2'b00;
      tx_disable_out <= 2'b11;
      rate_select_out <= 4'h0;
      module_mgmt_clock_o <= 2'b00;
      module_mgmt_clock_oe <= 2'b00;
      module_mgmt_data_o <= 2'b00;
      module_mgmt_data_oe <= 2'b00;
    end else begin
      async_reset_in <= ~run_reg;
      for (m = 0; m < 2; m = m + 1) begin
        port_power_on[m] <= ctrl_reg[m*`SPG_PORT_STRIDE+`SPG_C_PWR];
        tx_disable_out[m] <= ctrl_reg[m*`SPG_PORT_STRIDE+`SPG_C_TXDIS];
        rate_select_out[2*m] <= ctrl_reg[m*`SPG_PORT_STRIDE+`SPG_C_RS0];
        rate_select_out[2*m+1] <= ctrl_reg[m*`SPG_PORT_STRIDE+`SPG_C_RS1];
        // open drain: only pull low, never drive high
        module_mgmt_clock_o[m] <= 1'b0;
        module_mgmt_clock_oe[m] <= ctrl_reg[m*`SPG_PORT_STRIDE+`SPG_C_SCL];
        module_mgmt_data_o[m] <= 1'b0;
        module_mgmt_data_oe[m] <= ctrl_reg[m*`SPG_PORT_STRIDE+`SPG_C_SDA];
      end
    end
  end
endmodule // spg_glue

/* spg_glue_props.sv */
// assertions on the socket glue top-level ports
module spg_glue_props (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb request and answer
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // outputs watched
  input wire socket_clock_forty,
  input wire async_reset_in,
  input wire [1:0] port_power_on,
  input wire [1:0] tx_disable_out,
  input wire [3:0] rate_select_out,
  input wire [1:0] module_mgmt_clock_o,
  input wire [1:0] module_mgmt_data_o,
  input wire [1:0] module_mgmt_clock_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed writes, decoded once so the properties stay short
  wire wr = psel && penable && pready && pwrite;
  wire ctrl_wr = wr && paddr == 12'h000;
  wire run1 = wr && paddr == 12'h018 && pwdata[0];
  wire run0 = wr && paddr == 12'h018 && !pwdata[0];
  // one socket clock period: two cycles high, then three low
  sequence s_hi;
    socket_clock_forty [*2];
  endsequence
  sequence s_lo;
    (!socket_clock_forty) [*3];
  endsequence
  property p_sclk;
    $rose(socket_clock_forty) |-> s_hi ##1 s_lo ##1 socket_clock_forty;
  endproperty
  a_sclk: assert property (p_sclk) else $error("socket clock period not five cycles");
  property p_mgmt;
    module_mgmt_clock_o == 2'b00 && module_mgmt_data_o == 2'b00;
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("management line driven high");
  // controls move only as the echo of a control write
  property p_ctl_src;
    $changed({port_power_on, tx_disable_out, rate_select_out, module_mgmt_clock_oe}) |->
      $past(ctrl_wr) || $past(ctrl_wr, 2);
  endproperty
  a_ctl_src: assert property (p_ctl_src) else $error("control output moved without write");
  property p_txd;
    ctrl_wr |-> ##2 tx_disable_out == {$past(pwdata[8], 2), $past(pwdata[0], 2)};
  endproperty
  a_txd: assert property (p_txd) else $error("tx disable not from control write");
  property p_pwr;
    ctrl_wr |-> ##2 port_power_on == {$past(pwdata[11], 2), $past(pwdata[3], 2)};
  endproperty
  a_pwr: assert property (p_pwr) else $error("power enable not from control write");
  property p_oe;
    ctrl_wr |-> ##2 module_mgmt_clock_oe == {$past(pwdata[12], 2), $past(pwdata[4], 2)};
  endproperty
  a_oe: assert property (p_oe) else $error("clock pull-low not from control write");
  property p_run_rel;
    $fell(async_reset_in) |-> $past(run1) || $past(run1, 2);
  endproperty
  a_run_rel: assert property (p_run_rel) else $error("user reset released without run");
  property p_run_set;
    $rose(async_reset_in) |-> $past(run0) || $past(run0, 2);
  endproperty
  a_run_set: assert property (p_run_set) else $error("user reset raised without stop");
endmodule // spg_glue_props
bind spg_glue spg_glue_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata), .socket_clock_forty(socket_clock_forty),
  .async_reset_in(async_reset_in), .port_power_on(port_power_on), .tx_disable_out(tx_disable_out),
  .rate_select_out(rate_select_out), .module_mgmt_clock_o(module_mgmt_clock_o),
  .module_mgmt_data_o(module_mgmt_data_o), .module_mgmt_clock_oe(module_mgmt_clock_oe));

/* spg_cage.sv */
// two-cage model: status levels, power good, pulled-up management lines
module spg_cage #(parameter logic [95:0] SID = 96'h0) (
  // clock and bench commands
  input wire pclk,
  input wire [7:0] cmd,
  input wire [1:0] ovp,
  // from the glue
  input wire [1:0] pon,
  input wire [1:0] scoe,
  input wire [1:0] sdoe,
  // toward the glue
  output logic [1:0] flt,
  output logic [1:0] los,
  output logic [1:0] prs,
  output logic [1:0] vld,
  output logic [1:0] pok,
  output logic [1:0] sci,
  output logic [1:0] sdi,
  output logic [95:0] sid
);
  logic [95:0] junk = 96'h0; // flips each cycle so a stale id never looks valid
  assign {vld, prs, los, flt} = cmd;
  assign sci = ~scoe;
  assign sdi = ~sdoe;
  assign sid = {vld[1] ? SID[95:48] : junk[95:48], vld[0] ? SID[47:0] : junk[47:0]};
  // power good follows enable one cycle late, dropped on over-power
  always @(posedge pclk) begin
    pok <= pon & ~ovp;
    junk <= ~junk;
  end
endmodule // spg_cage

/* test_spg_glue.sv */
// bench: apb driven random and corner checks of the socket glue
module test_spg_glue;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [95:0] SID = 96'h5A5A_C3C3_0F0F_1234_5678_9ABC; // arbitrary
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sl;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, v, rs = 32'h059D2CCC;
  logic pready, pslverr, sclk, arst;
  logic [1:0] flt, los, prs, vld, pon, pok, txd, sci, scoe, sdi, sdoe, ovp = 0;
  logic [3:0] rsel;
  logic [7:0] st = 0;
  logic [95:0] sid;
  int fails = 0, n_tests = 0, sc_n = 0;
  spg_glue DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .socket_clock_forty(sclk), .async_reset_in(arst), .tx_fault_in(flt), .rx_signal_lost(los),
    .module_present_flag(prs), .station_id_valid(vld), .port_station_id(sid), .port_power_on(pon),
    .port_power_ok(pok), .tx_disable_out(txd), .rate_select_out(rsel), .module_mgmt_clock_i(sci),
    .module_mgmt_clock_o(), .module_mgmt_clock_oe(scoe), .module_mgmt_data_i(sdi),
    .module_mgmt_data_o(), .module_mgmt_data_oe(sdoe));
  spg_cage #(.SID(SID)) u_cage (.pclk(pclk), .cmd(st), .ovp(ovp), .pon(pon), .scoe(scoe), .sdoe(sdoe),
    .flt(flt), .los(los), .prs(prs), .vld(vld), .pok(pok), .sci(sci), .sdi(sdi), .sid(sid));
  initial forever #2.5 pclk = ~pclk;
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // status word from commanded levels and control bits; sticky bit left out
  function automatic logic [31:0] ex_st(input logic [7:0] c, input logic [13:0] cr);
    logic [31:0] e;
    e = 0;
    for (int p = 0; p < 2; p++) e[8 * p +: 7] = {~cr[8 * p + 5], ~cr[8 * p + 4], cr[8 * p + 3], c[6 + p],
      c[4 + p], c[2 + p], c[p]};
    return e;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one apb transfer; waits for pready with a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    // a missing answer is a mismatch and ends the run at once
    if (pready !== 1'b1) begin
      fails++;
      stop_test;
    end else begin
      rd = prdata;
      sl = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  // sticky power-fail: clear then read back with over-power set or not
  task automatic pf(input logic [1:0] o, input logic [31:0] e);
    ovp <= o;
    repeat (8) @(posedge pclk);
    apb(1, 12'h004, 32'h8080);
    apb(0, 12'h004, 0);
    chk(rd & 32'h9090, e);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    chk(arst, 1);
    apb(0, 12'h000, 0);
    chk(rd, 32'h101);
    apb(1, 12'h018, 1);
    repeat (3) @(posedge pclk);
    chk(arst, 0);
    // any 20 cycles hold four socket periods of two high cycles each
    repeat (20) begin
      @(posedge pclk);
      if (sclk === 1'b1) sc_n++;
    end
    chk(sc_n, 8);
    repeat (8) begin
      v = xs();
      st <= v[7:0];
      v = xs() & 32'h3F3F;
      apb(1, 12'h000, v);
      repeat (6) @(posedge pclk);
      chk(txd, {v[8], v[0]});
      chk(pon, {v[11], v[3]});
      chk(rsel, {v[10:9], v[2:1]});
      chk({sdoe, scoe}, {v[13], v[5], v[12], v[4]});
      apb(0, 12'h004, 0);
      chk(rd & 32'h7F7F, ex_st(st, v[13:0]));
      for (int p = 0; p < 2; p++) begin
        apb(0, 12'(8 * p + 8), 0);
        chk(rd, st[6 + p] ? SID[48 * p +: 32] : 0);
        apb(0, 12'(8 * p + 12), 0);
        chk(rd, st[6 + p] ? {16'h0, SID[48 * p + 32 +: 16]} : 0);
      end
    end
    apb(1, 12'h01C, 32'hFFFFFFFF);
    chk(sl, 1);
    apb(0, 12'h000, 0);
    chk(rd, v);
    apb(1, 12'h000, 32'h0808);
    chk(sl, 0);
    pf(2'b11, 32'h8080);
    pf(2'b00, 32'h1010);
    apb(1, 12'h018, 0);
    repeat (3) @(posedge pclk);
    chk(arst, 1);
    // run again, read it back, then a reset in mid-run
    apb(1, 12'h018, 1);
    apb(0, 12'h018, 0);
    chk(rd, 1);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk(arst, 1);
    chk({pon, txd}, 4'h3);
    presetn <= 1;
    apb(0, 12'h018, 0);
    chk(rd, 0);
    apb(0, 12'h000, 0);
    chk(rd, 32'h101);
    stop_test;
  end
endmodule // test_spg_glue
